// ---- adc_pair_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_pair_reg (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // New reading
    input wire logic load_in,
    input wire logic [poe_result_pkg::ADC_WIDTH-1:0] count_in,
    // Byte pair
    output logic [7:0] low_byte_out,
    output logic [7:0] high_byte_out
);

    // ==========================================================================
    // Split storage
    // ==========================================================================
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            low_byte_out <= poe_result_pkg::RESULT_RESET;
            high_byte_out <= poe_result_pkg::RESULT_RESET;
        end else if (load_in) begin
            low_byte_out <= {7'h00, count_in[0]};
            high_byte_out <= count_in[poe_result_pkg::ADC_WIDTH-1:1];
        end
    end

endmodule // adc_pair_reg
`default_nettype wire

// ---- legacy_nibble_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module legacy_nibble_reg (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // New outcome
    input wire logic load_in,
    input wire logic [3:0] code_in,
    // Held outcome
    output logic [3:0] code_out
);

    // ==========================================================================
    // Outcome storage
    // ==========================================================================
    // An undefined code would be meaningless to software, so it is dropped and
    // the previous outcome stays visible.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            code_out <= poe_result_pkg::LEGACY_RESET;
        end else if (load_in && poe_result_pkg::legacy_code_legal(code_in)) begin
            code_out <= code_in;
        end
    end

endmodule // legacy_nibble_reg
`default_nettype wire

// ---- mgmt_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mgmt_host_model (
    // Clock
    input wire logic core_clk_in,
    // Register access
    output var poe_result_pkg::reg_req_t reg_req_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    input wire logic write_ignored_in
);
    initial reg_req_out = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};

    // ==========================================================================
    // Bus cycles
    // ==========================================================================
    task automatic access(input logic is_write, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ack);
        @(posedge core_clk_in);
        reg_req_out <= '{rd: ~is_write, wr: is_write, addr: addr, wdata: wdata};
        @(posedge core_clk_in);
        // Released lines carry inverted values so a stale address is never taken for a live one.
        reg_req_out <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        rdata = reg_rdata_in;
        ack = is_write ? write_ignored_in : reg_rvalid_in;
    endtask

    // ==========================================================================
    // Conversions done on the host side
    // ==========================================================================
    function automatic int join_count(input logic [7:0] low, input logic [7:0] high);
        return int'({high, low[0]});
    endfunction

    // Result is in tenths of a milliampere so the arithmetic stays integral.
    function automatic int current_tenth_ma(input int count);
        return 24 * count - 100;
    endfunction

    // Result is in hundredths of a volt.
    function automatic int out_volt_centi(input int supply, input int pin);
        return 15 * (supply - pin);
    endfunction
endmodule // mgmt_host_model
`default_nettype wire

// ---- poe_port_measurement_result_regs.sv ----
// Notes on behaviour
// - Port 4 legacy outcome is bits 7..4 of the legacy result register, reset zero.
// - Port 3 legacy outcome is bits 3..0 of that register, reset zero.
// - Codes 0 none, 1 valid capacitance, 2 could not discharge.
// - Code 4 first measurement over ceiling, 5 second over ceiling.
// - Code 6 when the two measured voltages differ too little.
// - Port 1 current low bit sits in bit 0 of the lower byte.
// - Port 1 current upper eight bits fill the following byte.
// - Every reading is one unsigned count, low bit plus eight high bits.
// - Port 2 pin voltage uses the same low bit and high byte split.
// - Port 1 pin voltage sits in its own byte pair, same split.
// - Port 3 current pair, four addresses above port 2 current.
// - Port 2 current pair uses the same split.
// - Input supply count sits in its own pair, upper bits high.
`timescale 1ns/100ps
`default_nettype none
module poe_port_measurement_result_regs (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Results from the measurement engine
    input wire poe_result_pkg::meas_update_t meas_in,
    input wire poe_result_pkg::legacy_update_t legacy_in,
    // Register access from the management bus engine
    input wire poe_result_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic write_ignored_out
);

    // ==========================================================================
    // Storage
    // ==========================================================================
    logic [7:0] low_bytes [poe_result_pkg::NUM_PAIRS];
    logic [7:0] high_bytes [poe_result_pkg::NUM_PAIRS];
    logic [3:0] legacy_codes [2];
    logic [3:0] legacy_code_p3;
    logic [3:0] legacy_code_p4;
    logic meas_chan_ok;

    // A channel code that is not one-hot must not load several pairs at once.
    assign meas_chan_ok = $onehot(meas_in.chan);

    genvar g;
    generate
        for (g = 0; g < poe_result_pkg::NUM_PAIRS; g++) begin : gen_pair
            adc_pair_reg u_pair (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .load_in(meas_in.valid && meas_chan_ok && meas_in.chan[g]),
                .count_in(meas_in.count),
                .low_byte_out(low_bytes[g]),
                .high_byte_out(high_bytes[g])
            );
        end
        for (g = 0; g < 2; g++) begin : gen_legacy
            legacy_nibble_reg u_legacy (
                .core_clk_in(core_clk_in),
                .reset_n_in(reset_n_in),
                .load_in(legacy_in.valid && (legacy_in.port4 == g[0])),
                .code_in(legacy_in.code),
                .code_out(legacy_codes[g])
            );
        end
    endgenerate

    assign legacy_code_p3 = legacy_codes[0];
    assign legacy_code_p4 = legacy_codes[1];

    // ==========================================================================
    // Address decode
    // ==========================================================================
    function automatic logic [2:0] pair_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = poe_result_pkg::NO_PAIR;
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            if (addr[7:1] == poe_result_pkg::PAIR_LOW_ADDR[i][7:1]) begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction

    // ==========================================================================
    // Coherent pair read
    // ==========================================================================
    // Reading the low byte freezes the matching high byte, so a low-then-high
    // read returns halves of one reading even if the engine updates between.
    logic shadow_valid;
    logic [2:0] shadow_idx;
    logic [7:0] shadow_high;
    logic [2:0] req_idx;

    assign req_idx = pair_index(reg_req_in.addr);

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            shadow_valid <= 1'b0;
            shadow_idx <= poe_result_pkg::NO_PAIR;
            shadow_high <= poe_result_pkg::RESULT_RESET;
        end else if (reg_req_in.rd && req_idx != poe_result_pkg::NO_PAIR) begin
            if (!reg_req_in.addr[0]) begin
                shadow_valid <= 1'b1;
                shadow_idx <= req_idx;
                shadow_high <= high_bytes[req_idx];
            end else if (shadow_idx == req_idx) begin
                shadow_valid <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Read data
    // ==========================================================================
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = poe_result_pkg::UNMAPPED_READ;
        if (reg_req_in.addr == poe_result_pkg::LEGACY_P34_ADDR) begin
            next_rdata = {legacy_code_p4, legacy_code_p3};
        end else if (req_idx != poe_result_pkg::NO_PAIR) begin
            if (!reg_req_in.addr[0]) begin
                next_rdata = low_bytes[req_idx];
            end else if (shadow_valid && shadow_idx == req_idx) begin
                next_rdata = shadow_high;
            end else begin
                next_rdata = high_bytes[req_idx];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= poe_result_pkg::RESULT_RESET;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.rd;
            if (reg_req_in.rd) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // ==========================================================================
    // Writes
    // ==========================================================================
    // Nothing here takes write data; the pulse only tells the bus engine that
    // the byte went nowhere.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            write_ignored_out <= 1'b0;
        end else begin
            write_ignored_out <= reg_req_in.wr;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    logic [103:0] all_bytes;
    always_comb begin
        all_bytes = {96'h0, legacy_code_p4, legacy_code_p3};
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            all_bytes[8 + 16 * i +: 16] = {high_bytes[i], low_bytes[i]};
        end
    end

    // These checks leave one idle cycle between a load and its read, and only a
    // snapshot of the same pair may stand in for live data.
    sequence s_load_read(poe_result_pkg::meas_chan_t ch, logic [7:0] addr);
        (meas_in.valid && meas_in.chan == ch && !reg_req_in.rd) ##1
        (!meas_in.valid && !reg_req_in.rd) ##1
        (reg_req_in.rd && reg_req_in.addr == addr && !(shadow_valid && shadow_idx == req_idx));
    endsequence

    property p_legacy_p4;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::LEGACY_P34_ADDR) |=>
        reg_rdata_out[poe_result_pkg::LEGACY_P4_MSB:poe_result_pkg::LEGACY_P4_LSB] == $past(legacy_code_p4);
    endproperty
    a_legacy_p4: assert property (p_legacy_p4) else $error("port 4 legacy code misplaced");

    property p_legacy_p3;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::LEGACY_P34_ADDR) |=>
        reg_rdata_out[poe_result_pkg::LEGACY_P3_MSB:poe_result_pkg::LEGACY_P3_LSB] == $past(legacy_code_p3);
    endproperty
    a_legacy_p3: assert property (p_legacy_p3) else $error("port 3 legacy code misplaced");

    property p_legacy_legal;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        poe_result_pkg::legacy_code_legal(legacy_code_p3) && poe_result_pkg::legacy_code_legal(legacy_code_p4);
    endproperty
    a_legacy_legal: assert property (p_legacy_legal) else $error("undefined legacy code held");

    property p_legacy_over;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (legacy_in.valid && legacy_in.port4 && legacy_in.code == poe_result_pkg::LEG_SECOND_HIGH) |=>
        legacy_code_p4 == poe_result_pkg::LEG_SECOND_HIGH;
    endproperty
    a_legacy_over: assert property (p_legacy_over) else $error("over-ceiling code not taken");

    property p_legacy_diff;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (legacy_in.valid && !legacy_in.port4 && legacy_in.code == poe_result_pkg::LEG_DIFF_LOW) |=>
        legacy_code_p3 == poe_result_pkg::LEG_DIFF_LOW;
    endproperty
    a_legacy_diff: assert property (p_legacy_diff) else $error("small difference code not taken");

    property p_p1_cur_low;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P1_CUR, poe_result_pkg::P1_CUR_LO_ADDR) |=>
        reg_rdata_out == {7'h00, $past(meas_in.count[0], 3)};
    endproperty
    a_p1_cur_low: assert property (p_p1_cur_low) else $error("port 1 current low bit wrong");

    property p_p1_cur_high;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P1_CUR, poe_result_pkg::P1_CUR_HI_ADDR) |=>
        reg_rdata_out == $past(meas_in.count[8:1], 3);
    endproperty
    a_p1_cur_high: assert property (p_p1_cur_high) else $error("port 1 current high byte wrong");

    property p_coherent;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::P2_CUR_LO_ADDR) ##1
        (!reg_req_in.rd) ##1
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::P2_CUR_HI_ADDR) |=>
        reg_rdata_out == $past(high_bytes[2], 3);
    endproperty
    a_coherent: assert property (p_coherent) else $error("pair read not coherent");

    property p_p2_volt_low;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P2_VOLT, poe_result_pkg::P2_VOLT_LO_ADDR) |=>
        reg_rdata_out == {7'h00, $past(meas_in.count[0], 3)};
    endproperty
    a_p2_volt_low: assert property (p_p2_volt_low) else $error("port 2 voltage low bit wrong");

    property p_p1_volt_high;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P1_VOLT, poe_result_pkg::P1_VOLT_HI_ADDR) |=>
        reg_rdata_out == $past(meas_in.count[8:1], 3);
    endproperty
    a_p1_volt_high: assert property (p_p1_volt_high) else $error("port 1 voltage high byte wrong");

    property p_p3_cur_high;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P3_CUR, poe_result_pkg::P3_CUR_HI_ADDR) |=>
        reg_rdata_out == $past(meas_in.count[8:1], 3);
    endproperty
    a_p3_cur_high: assert property (p_p3_cur_high) else $error("port 3 current high byte wrong");

    property p_p2_cur_low;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_P2_CUR, poe_result_pkg::P2_CUR_LO_ADDR) |=>
        reg_rdata_out == {7'h00, $past(meas_in.count[0], 3)};
    endproperty
    a_p2_cur_low: assert property (p_p2_cur_low) else $error("port 2 current low bit wrong");

    property p_vin_high;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_load_read(poe_result_pkg::CHAN_VIN, poe_result_pkg::VIN_HI_ADDR) |=>
        reg_rdata_out == $past(meas_in.count[8:1], 3);
    endproperty
    a_vin_high: assert property (p_vin_high) else $error("supply count high byte wrong");

    property p_write_ignored;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_req_in.wr && !meas_in.valid && !legacy_in.valid) |=>
        (all_bytes == $past(all_bytes)) && write_ignored_out;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed a result");

    c_legacy_read: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
        reg_req_in.rd && reg_req_in.addr == poe_result_pkg::LEGACY_P34_ADDR && legacy_code_p4 != 4'h0);
    c_coherent_update: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::P1_CUR_LO_ADDR) ##2
        (meas_in.valid && meas_in.chan == poe_result_pkg::CHAN_P1_CUR) ##2
        (reg_req_in.rd && reg_req_in.addr == poe_result_pkg::P1_CUR_HI_ADDR));
    c_write: cover property (@(posedge core_clk_in) disable iff (!reset_n_in) reg_req_in.wr);
    c_unmapped: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
        reg_req_in.rd && reg_req_in.addr == 8'h4a);

endmodule // poe_port_measurement_result_regs
`default_nettype wire

// ---- poe_port_measurement_result_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module poe_port_measurement_result_regs_tb_top;
    logic core_clk_in = 1'b0;
    logic reset_n_in;
    poe_result_pkg::meas_update_t meas_in;
    poe_result_pkg::legacy_update_t legacy_in;
    poe_result_pkg::reg_req_t reg_req;
    logic [7:0] rdata;
    logic rvalid;
    logic wr_ignored;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    logic [8:0] counts [6] = '{9'h1ff, 9'h001, 9'h100, 9'h0ff, 9'h155, 9'h0aa};

    always #10 core_clk_in = ~core_clk_in;

    poe_port_measurement_result_regs dut_u (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .meas_in(meas_in),
        .legacy_in(legacy_in),
        .reg_req_in(reg_req),
        .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid),
        .write_ignored_out(wr_ignored)
    );

    mgmt_host_model host_u (
        .core_clk_in(core_clk_in),
        .reg_req_out(reg_req),
        .reg_rdata_in(rdata),
        .reg_rvalid_in(rvalid),
        .write_ignored_in(wr_ignored)
    );

    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        logic ack;
        host_u.access(1'b0, addr, 8'h00, data, ack);
        check("read valid", {15'h0, ack}, 16'h0001);
    endtask

    task automatic load_meas(input int idx, input logic [5:0] chan_bits, input logic [8:0] cnt);
        @(posedge core_clk_in);
        meas_in <= '{valid: 1'b1, chan: poe_result_pkg::meas_chan_t'(chan_bits), count: cnt};
        @(posedge core_clk_in);
        meas_in.valid <= 1'b0;
    endtask

    task automatic load_legacy(input logic port4, input logic [3:0] code);
        @(posedge core_clk_in);
        legacy_in <= '{valid: 1'b1, port4: port4, code: code};
        @(posedge core_clk_in);
        legacy_in.valid <= 1'b0;
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic check_reset();
        logic [7:0] d;
        rd(poe_result_pkg::LEGACY_P34_ADDR, d);
        check("legacy reset", {8'h0, d}, 16'h0000);
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            rd(poe_result_pkg::PAIR_LOW_ADDR[i], d);
            check("pair low reset", {8'h0, d}, 16'h0000);
            rd(poe_result_pkg::PAIR_LOW_ADDR[i] + 8'h01, d);
            check("pair high reset", {8'h0, d}, 16'h0000);
        end
    endtask

    task automatic check_legacy();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            load_legacy(1'b1, codes[i]);
            load_legacy(1'b0, codes[(i + 1) % 6]);
            rd(poe_result_pkg::LEGACY_P34_ADDR, d);
            check("legacy byte", {8'h0, d}, {8'h0, codes[i], codes[(i + 1) % 6]});
        end
        // A code outside the documented set must leave the held one in place.
        load_legacy(1'b0, 4'h3);
        rd(poe_result_pkg::LEGACY_P34_ADDR, d);
        check("legacy illegal", {8'h0, d}, {8'h0, codes[5], codes[0]});
    endtask

    task automatic check_pairs();
        logic [7:0] d;
        // Each read comes straight after its load, so the live-read properties are exercised.
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            load_meas(i, 6'h01 << i, counts[5 - i]);
            rd(poe_result_pkg::PAIR_LOW_ADDR[i] + 8'h01, d);
            check("load then high", {8'h0, d}, {8'h0, counts[5 - i][8:1]});
            load_meas(i, 6'h01 << i, counts[i]);
            rd(poe_result_pkg::PAIR_LOW_ADDR[i], d);
            check("load then low", {8'h0, d}, {15'h0, counts[i][0]});
        end
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            load_meas(i, 6'h01 << i, counts[i]);
        end
        for (int i = 0; i < poe_result_pkg::NUM_PAIRS; i++) begin
            rd(poe_result_pkg::PAIR_LOW_ADDR[i], d);
            check("pair low", {8'h0, d}, {15'h0, counts[i][0]});
            rd(poe_result_pkg::PAIR_LOW_ADDR[i] + 8'h01, d);
            check("pair high", {8'h0, d}, {8'h0, counts[i][8:1]});
        end
        load_meas(0, 6'h03, 9'h000);
        rd(poe_result_pkg::P1_CUR_HI_ADDR, d);
        check("bad channel", {8'h0, d}, {8'h0, counts[0][8:1]});
    endtask

    task automatic check_host_math();
        logic [7:0] lo;
        logic [7:0] hi;
        int cur;
        int pin;
        int sup;
        rd(poe_result_pkg::P3_CUR_LO_ADDR, lo);
        rd(poe_result_pkg::P3_CUR_HI_ADDR, hi);
        cur = host_u.join_count(lo, hi);
        check("current tenth ma", 16'(host_u.current_tenth_ma(cur)), 16'(24 * 341 - 100));
        rd(poe_result_pkg::P1_VOLT_LO_ADDR, lo);
        rd(poe_result_pkg::P1_VOLT_HI_ADDR, hi);
        pin = host_u.join_count(lo, hi);
        rd(poe_result_pkg::VIN_LO_ADDR, lo);
        rd(poe_result_pkg::VIN_HI_ADDR, hi);
        sup = host_u.join_count(lo, hi);
        check("out volt centi", 16'(host_u.out_volt_centi(sup, pin)), 16'(15 * (170 - 1)));
    endtask

    task automatic check_snapshot();
        logic [7:0] d;
        load_meas(0, 6'h01, 9'h0f3);
        rd(poe_result_pkg::P1_CUR_LO_ADDR, d);
        check("snap low", {8'h0, d}, 16'h0001);
        load_meas(0, 6'h01, 9'h10c);
        rd(poe_result_pkg::P1_CUR_HI_ADDR, d);
        check("snap high", {8'h0, d}, 16'h0079);
        rd(poe_result_pkg::P1_CUR_HI_ADDR, d);
        check("live high", {8'h0, d}, 16'h0086);
    endtask

    task automatic check_writes();
        logic [7:0] d;
        logic ack;
        host_u.access(1'b1, poe_result_pkg::P1_CUR_HI_ADDR, 8'h5a, d, ack);
        check("write ignored", {15'h0, ack}, 16'h0001);
        host_u.access(1'b1, poe_result_pkg::LEGACY_P34_ADDR, 8'hff, d, ack);
        check("write ignored", {15'h0, ack}, 16'h0001);
        rd(poe_result_pkg::P1_CUR_HI_ADDR, d);
        check("after write", {8'h0, d}, 16'h0086);
        rd(poe_result_pkg::LEGACY_P34_ADDR, d);
        check("after write", {8'h0, d}, {8'h0, codes[5], codes[0]});
        rd(8'h37, d);
        check("unmapped", {8'h0, d}, 16'h0000);
        rd(8'h4a, d);
        check("unmapped", {8'h0, d}, 16'h0000);
    endtask

    // ==========================================================================
    // Run control
    // ==========================================================================
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        reset_n_in = 1'b0;
        meas_in = '0;
        legacy_in = '0;
        repeat (3) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        check_reset();
        check_legacy();
        check_pairs();
        check_host_math();
        check_snapshot();
        check_writes();
        results();
    end
endmodule // poe_port_measurement_result_regs_tb_top
`default_nettype wire

// ---- poe_result_pkg.sv ----
`default_nettype none
package poe_result_pkg;

    // ==========================================================================
    // Register offsets on the management bus
    // ==========================================================================
    localparam logic [7:0] LEGACY_P34_ADDR = 8'h36;
    localparam logic [7:0] P1_CUR_LO_ADDR = 8'h40;
    localparam logic [7:0] P1_CUR_HI_ADDR = 8'h41;
    localparam logic [7:0] P1_VOLT_LO_ADDR = 8'h42;
    localparam logic [7:0] P1_VOLT_HI_ADDR = 8'h43;
    localparam logic [7:0] P2_CUR_LO_ADDR = 8'h44;
    localparam logic [7:0] P2_CUR_HI_ADDR = 8'h45;
    localparam logic [7:0] P2_VOLT_LO_ADDR = 8'h46;
    localparam logic [7:0] P2_VOLT_HI_ADDR = 8'h47;
    localparam logic [7:0] P3_CUR_LO_ADDR = 8'h48;
    localparam logic [7:0] P3_CUR_HI_ADDR = 8'h49;
    localparam logic [7:0] VIN_LO_ADDR = 8'h50;
    localparam logic [7:0] VIN_HI_ADDR = 8'h51;

    // ==========================================================================
    // Field layout, reset values and sizes
    // ==========================================================================
    localparam int ADC_WIDTH = 9;
    localparam int NUM_PAIRS = 6;
    localparam int LEGACY_P4_MSB = 7;
    localparam int LEGACY_P4_LSB = 4;
    localparam int LEGACY_P3_MSB = 3;
    localparam int LEGACY_P3_LSB = 0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [3:0] LEGACY_RESET = 4'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [2:0] NO_PAIR = 3'h7;

    // Pair index to low-byte address; the high byte sits one address above.
    localparam logic [7:0] PAIR_LOW_ADDR [NUM_PAIRS] = '{
        P1_CUR_LO_ADDR, P1_VOLT_LO_ADDR, P2_CUR_LO_ADDR,
        P2_VOLT_LO_ADDR, P3_CUR_LO_ADDR, VIN_LO_ADDR};

    // ==========================================================================
    // Legacy detection outcome codes
    // ==========================================================================
    localparam logic [3:0] LEG_NONE = 4'h0;
    localparam logic [3:0] LEG_VALID = 4'h1;
    localparam logic [3:0] LEG_NO_DISCHARGE = 4'h2;
    localparam logic [3:0] LEG_FIRST_HIGH = 4'h4;
    localparam logic [3:0] LEG_SECOND_HIGH = 4'h5;
    localparam logic [3:0] LEG_DIFF_LOW = 4'h6;

    function automatic logic legacy_code_legal(input logic [3:0] code);
        return (code == LEG_NONE) || (code == LEG_VALID) || (code == LEG_NO_DISCHARGE) ||
               (code == LEG_FIRST_HIGH) || (code == LEG_SECOND_HIGH) || (code == LEG_DIFF_LOW);
    endfunction

    // ==========================================================================
    // Carriers
    // ==========================================================================
    typedef enum logic [5:0] {
        CHAN_P1_CUR = 6'b000001,
        CHAN_P1_VOLT = 6'b000010,
        CHAN_P2_CUR = 6'b000100,
        CHAN_P2_VOLT = 6'b001000,
        CHAN_P3_CUR = 6'b010000,
        CHAN_VIN = 6'b100000
    } meas_chan_t;

    typedef struct packed {
        logic valid;
        meas_chan_t chan;
        logic [ADC_WIDTH-1:0] count;
    } meas_update_t;

    typedef struct packed {
        logic valid;
        logic port4;
        logic [3:0] code;
    } legacy_update_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage
`default_nettype wire
